// *** logic/bcr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module bcr_regs
	import bcr_pkg::*;
#(
	parameter logic [3:0] REV_CODE = 4'h1, // arbitrary value
	parameter logic [3:0] SUB_REV_CODE = 4'h0 // arbitrary value
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic BOARD_RESET,
	input wire logic HARD_RESET,
	input wire logic PHY_RESET_TOGGLE,
	input wire logic FLASH_READY,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR_STROBE,
	input wire logic RD_STROBE,
	output logic [7:0] RDATA,
	output logic PORT_A_GIGE_ENABLE,
	output logic PORT_A_EXPANSION_ROUTE,
	output logic PORT_A_TDM_ENABLE,
	output logic PORT_A_GMII_ENABLE,
	output logic PORT_A_RGMII_ENABLE,
	output logic PORT_A_TBI_ENABLE,
	output logic PORT_A_RTBI_ENABLE,
	output logic PORT_A_MII_ENABLE,
	output logic PORT_B_GIGE_ENABLE,
	output logic PORT_B_EXPANSION_ROUTE,
	output logic PORT_B_TDM_ENABLE,
	output logic PORT_B_GMII_ENABLE,
	output logic PORT_B_RGMII_ENABLE,
	output logic PORT_B_TBI_ENABLE,
	output logic PORT_B_RTBI_ENABLE,
	output logic PORT_B_MII_ENABLE,
	output logic RTC_RESET,
	output logic FLASH_WRITE_PROTECT,
	output logic LINK_CLK_SEL_LO,
	output logic LINK_CLK_SEL_HI,
	output logic LINK_SPREAD_SEL_LO,
	output logic LINK_SPREAD_SEL_HI,
	output logic PCI_CLK_ENABLE,
	output logic PHY0_REFCLK_DISABLE,
	output logic PHY0_EXCHANGE_ENABLE,
	output logic PHY1_REFCLK_DISABLE,
	output logic PHY1_EXCHANGE_ENABLE,
	output logic [1:0] PORT_A_MODE_FIELD,
	output logic [1:0] PORT_B_MODE_FIELD
);

////////////////////////////////////////////////////////////////////////////////
// declarations

	// first stage of pin synchronisers
	logic [SY_W-1:0] sync1_reg;
	// second stage, the only one logic reads
	logic [SY_W-1:0] sync2_reg;
	// last toggle level seen
	logic toggle_prev_reg;
	// toggle went from one back to zero
	logic phy_reload;
	// board and hard reset after sync
	logic board_reset_signal;
	logic hard_reset_signal;
	// flash ready after sync
	logic flash_ready_status;
	// the five registers
	logic [7:0] port_a_routing_ctrl_reg;
	logic [7:0] port_b_routing_flash_ctrl_reg;
	logic [7:0] link_clock_select_reg;
	logic [7:0] phy_mode_ctrl_reg;
	logic [7:0] logic_revision_reg;
	// revision reset value
	logic [7:0] rev_def;
	// write strobes per register
	logic wr_a;
	logic wr_b;
	logic wr_c;
	logic wr_p;
	logic wr_r;
	// read mux value and read data flop
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;
	// decoded routing flops
	bcr_route_t route_a_reg;
	bcr_route_t route_b_reg;
	// named field views
	logic port_a_gige_enable;
	logic port_a_full_width_select;
	logic port_a_tenbit_select;
	logic port_a_fast_enable;
	logic port_b_gige_enable;
	logic port_b_full_width_select;
	logic port_b_tenbit_select;
	logic port_b_fast_enable;

	assign rev_def = {REV_CODE, SUB_REV_CODE};

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

	// two flops per pin before any use
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			sync1_reg <= SYNC_DEF;
			sync2_reg <= SYNC_DEF;
		end else begin
			sync1_reg <= {FLASH_READY, PHY_RESET_TOGGLE, HARD_RESET, BOARD_RESET};
			sync2_reg <= sync1_reg;
		end
	end

	// remember toggle level for fall detect
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			toggle_prev_reg <= 1'b0;
		end else begin
			toggle_prev_reg <= sync2_reg[SY_TOG];
		end
	end

	// set to one then back to zero
	assign phy_reload = toggle_prev_reg & ~sync2_reg[SY_TOG];
	assign board_reset_signal = sync2_reg[SY_BRST];
	assign hard_reset_signal = sync2_reg[SY_HRST];
	assign flash_ready_status = sync2_reg[SY_FRDY];

////////////////////////////////////////////////////////////////////////////////
// write decode

	// full byte write to one register per strobe, except port B, which drops its ready bit
	assign wr_a = WR_STROBE && (ADDR == ADDR_PORT_A);
	assign wr_b = WR_STROBE && (ADDR == ADDR_PORT_B);
	assign wr_c = WR_STROBE && (ADDR == ADDR_CLOCK);
	assign wr_p = WR_STROBE && (ADDR == ADDR_PHY);
	assign wr_r = WR_STROBE && (ADDR == ADDR_REV);

////////////////////////////////////////////////////////////////////////////////
// registers

	// port A routing, reloads on board reset
	always_ff @(posedge CLOCK) begin
		if (RESET || board_reset_signal) begin
			port_a_routing_ctrl_reg <= PORT_A_DEF;
		end else if (wr_a) begin
			// reserved bits stored as written
			port_a_routing_ctrl_reg <= WDATA;
		end
	end

	// port B routing, reloads on hard reset
	always_ff @(posedge CLOCK) begin
		if (RESET || hard_reset_signal) begin
			port_b_routing_flash_ctrl_reg <= PORT_B_DEF;
		end else if (wr_b) begin
			// ready bit is not stored
			port_b_routing_flash_ctrl_reg <= WDATA & PORT_B_RW;
		end
	end

	// link clock select, reloads on hard reset
	always_ff @(posedge CLOCK) begin
		if (RESET || hard_reset_signal) begin
			link_clock_select_reg <= CLOCK_DEF;
		end else if (wr_c) begin
			link_clock_select_reg <= WDATA;
		end
	end

	// phy mode, reloads on hard reset or toggle fall
	always_ff @(posedge CLOCK) begin
		if (RESET || hard_reset_signal || phy_reload) begin
			phy_mode_ctrl_reg <= PHY_DEF;
		end else if (wr_p) begin
			phy_mode_ctrl_reg <= WDATA;
		end
	end

	// revision, reloads on power-on only
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			logic_revision_reg <= rev_def;
		end else if (wr_r) begin
			logic_revision_reg <= WDATA;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// read path

	// read mux, unmapped reads zero
	always_comb begin
		case (ADDR)
			ADDR_PORT_A: rdata_next = port_a_routing_ctrl_reg;
			// live ready level in its bit
			ADDR_PORT_B: rdata_next = (port_b_routing_flash_ctrl_reg & PORT_B_RW)
				| (flash_ready_status ? PORT_B_RO : ZERO_BYTE);
			ADDR_CLOCK: rdata_next = link_clock_select_reg;
			ADDR_PHY: rdata_next = phy_mode_ctrl_reg;
			ADDR_REV: rdata_next = logic_revision_reg;
			default: rdata_next = ZERO_BYTE;
		endcase
	end

	// data stands only the cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rdata_reg <= ZERO_BYTE;
		end else if (RD_STROBE) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= ZERO_BYTE;
		end
	end

	assign RDATA = rdata_reg;

////////////////////////////////////////////////////////////////////////////////
// routing decode

	// field views of the routing registers
	assign port_a_gige_enable = port_a_routing_ctrl_reg[F_GIGE];
	assign port_a_full_width_select = port_a_routing_ctrl_reg[F_FULL];
	assign port_a_tenbit_select = port_a_routing_ctrl_reg[F_TENBIT];
	assign port_a_fast_enable = port_a_routing_ctrl_reg[F_FAST];
	assign port_b_gige_enable = port_b_routing_flash_ctrl_reg[F_GIGE];
	assign port_b_full_width_select = port_b_routing_flash_ctrl_reg[F_FULL];
	assign port_b_tenbit_select = port_b_routing_flash_ctrl_reg[F_TENBIT];
	assign port_b_fast_enable = port_b_routing_flash_ctrl_reg[F_FAST];

	// port A pin selects, one cycle behind the register
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			route_a_reg <= bcr_route(PORT_A_DEF);
		end else begin
			route_a_reg <= bcr_route(port_a_routing_ctrl_reg);
		end
	end

	// port B pin selects, one cycle behind the register
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			route_b_reg <= bcr_route(PORT_B_DEF);
		end else begin
			route_b_reg <= bcr_route(port_b_routing_flash_ctrl_reg);
		end
	end

	// port A pins
	assign PORT_A_GIGE_ENABLE = route_a_reg[RT_GIGE];
	assign PORT_A_EXPANSION_ROUTE = route_a_reg[RT_EXP];
	assign PORT_A_TDM_ENABLE = route_a_reg[RT_EXP];
	assign PORT_A_GMII_ENABLE = route_a_reg[RT_GMII];
	assign PORT_A_RGMII_ENABLE = route_a_reg[RT_RGMII];
	assign PORT_A_TBI_ENABLE = route_a_reg[RT_TBI];
	assign PORT_A_RTBI_ENABLE = route_a_reg[RT_RTBI];
	assign PORT_A_MII_ENABLE = route_a_reg[RT_MII];
	// port B pins
	assign PORT_B_GIGE_ENABLE = route_b_reg[RT_GIGE];
	assign PORT_B_EXPANSION_ROUTE = route_b_reg[RT_EXP];
	assign PORT_B_TDM_ENABLE = route_b_reg[RT_EXP];
	assign PORT_B_GMII_ENABLE = route_b_reg[RT_GMII];
	assign PORT_B_RGMII_ENABLE = route_b_reg[RT_RGMII];
	assign PORT_B_TBI_ENABLE = route_b_reg[RT_TBI];
	assign PORT_B_RTBI_ENABLE = route_b_reg[RT_RTBI];
	assign PORT_B_MII_ENABLE = route_b_reg[RT_MII];

////////////////////////////////////////////////////////////////////////////////
// direct control pins

	// straight from register flops
	assign RTC_RESET = port_a_routing_ctrl_reg[F_TOP];
	assign FLASH_WRITE_PROTECT = port_b_routing_flash_ctrl_reg[F_TOP];
	assign LINK_CLK_SEL_LO = link_clock_select_reg[C_SEL_LO];
	assign LINK_CLK_SEL_HI = link_clock_select_reg[C_SEL_HI];
	assign LINK_SPREAD_SEL_LO = link_clock_select_reg[C_SS_LO];
	assign LINK_SPREAD_SEL_HI = link_clock_select_reg[C_SS_HI];
	assign PCI_CLK_ENABLE = link_clock_select_reg[C_PCI];
	assign PHY0_REFCLK_DISABLE = phy_mode_ctrl_reg[P0_DIS];
	assign PHY1_REFCLK_DISABLE = phy_mode_ctrl_reg[P1_DIS];
	assign PHY0_EXCHANGE_ENABLE = phy_mode_ctrl_reg[P0_XC];
	assign PHY1_EXCHANGE_ENABLE = phy_mode_ctrl_reg[P1_XC];
	assign PORT_A_MODE_FIELD = phy_mode_ctrl_reg[PA_HI:PA_LO];
	assign PORT_B_MODE_FIELD = phy_mode_ctrl_reg[PB_HI:PB_LO];

////////////////////////////////////////////////////////////////////////////////
// assertions

	// board reset pin reloads port A
	a_board_reload: assert property (@(posedge CLOCK) disable iff (RESET)
		board_reset_signal |=> port_a_routing_ctrl_reg == PORT_A_DEF)
		else $error("port A not reloaded by board reset");

	// port A decode follows its register
	a_port_a_decode: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) |-> route_a_reg == bcr_route($past(port_a_routing_ctrl_reg)))
		else $error("port A routing decode wrong");

	// width select only with gigabit on
	a_port_a_width: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) |-> PORT_A_GMII_ENABLE
		== ($past(port_a_gige_enable) && $past(port_a_full_width_select)))
		else $error("port A full width select wrong");

	// ten-bit pair is exclusive under gigabit
	a_port_a_tenbit: assert property (@(posedge CLOCK) disable iff (RESET)
		PORT_A_GIGE_ENABLE |-> PORT_A_TBI_ENABLE != PORT_A_RTBI_ENABLE)
		else $error("port A ten-bit pair wrong");

	// fast mode never with gigabit on
	a_port_a_fast: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) |-> PORT_A_MII_ENABLE
		== (!$past(port_a_gige_enable) && $past(port_a_fast_enable)))
		else $error("port A fast enable wrong");

	// clock chip reset follows a write
	a_rtc_hold: assert property (@(posedge CLOCK) disable iff (RESET)
		wr_a && !board_reset_signal |=> RTC_RESET == $past(WDATA[F_TOP]))
		else $error("clock chip reset not written");

	// hard reset reloads the three registers
	a_hard_reload: assert property (@(posedge CLOCK) disable iff (RESET)
		hard_reset_signal |=> port_b_routing_flash_ctrl_reg == PORT_B_DEF
		&& link_clock_select_reg == CLOCK_DEF && phy_mode_ctrl_reg == PHY_DEF)
		else $error("hard reset reload missing");

	// port B gigabit and expansion are opposite
	a_port_b_path: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) |-> PORT_B_EXPANSION_ROUTE == !$past(port_b_gige_enable)
		&& PORT_B_TDM_ENABLE == PORT_B_EXPANSION_ROUTE)
		else $error("port B path wrong");

	// port B selects gated by gigabit
	a_port_b_sel: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) |-> PORT_B_RGMII_ENABLE
		== ($past(port_b_gige_enable) && !$past(port_b_full_width_select))
		&& PORT_B_TBI_ENABLE == ($past(port_b_gige_enable) && $past(port_b_tenbit_select)))
		else $error("port B width or ten-bit wrong");

	// port B fast only with gigabit off
	a_port_b_fast: assert property (@(posedge CLOCK) disable iff (RESET)
		PORT_B_MII_ENABLE |-> !PORT_B_GIGE_ENABLE)
		else $error("port B fast enable with gigabit");

	// flash ready read back one cycle late
	a_flash_ready: assert property (@(posedge CLOCK) disable iff (RESET)
		RD_STROBE && ADDR == ADDR_PORT_B |=> RDATA[F_FLASH_RDY] == $past(flash_ready_status))
		else $error("flash ready bit read wrong");

	// toggle fall reloads phy mode
	a_phy_toggle: assert property (@(posedge CLOCK) disable iff (RESET)
		$fell(sync2_reg[SY_TOG]) |=> phy_mode_ctrl_reg == PHY_DEF)
		else $error("phy mode not reloaded after toggle");

	// read data gone one cycle after
	a_read_window: assert property (@(posedge CLOCK) disable iff (RESET)
		!RD_STROBE |=> RDATA == ZERO_BYTE)
		else $error("read data outside its cycle");

	// revision default after power-on
	a_rev_reload: assert property (@(posedge CLOCK)
		$fell(RESET) |-> logic_revision_reg == rev_def)
		else $error("revision default missing");

	// port A to expansion board
	c_port_a_exp: cover property (@(posedge CLOCK) disable iff (RESET)
		PORT_A_EXPANSION_ROUTE && PORT_A_MII_ENABLE);
	// port B in ten-bit mode
	c_port_b_tbi: cover property (@(posedge CLOCK) disable iff (RESET)
		PORT_B_TBI_ENABLE);
	// phy reload by toggle
	c_phy_toggle: cover property (@(posedge CLOCK) disable iff (RESET)
		phy_reload && PORT_A_MODE_FIELD == MODE_TBI);
	// flash busy seen on read
	c_flash_busy: cover property (@(posedge CLOCK) disable iff (RESET)
		RD_STROBE && ADDR == ADDR_PORT_B ##1 !RDATA[F_FLASH_RDY]);

endmodule : bcr_regs
`default_nettype wire

// *** logic/bcr_pkg.sv ***
package bcr_pkg;
	// register addresses, one byte each
	localparam logic [2:0] ADDR_PORT_A = 3'h0;
	localparam logic [2:0] ADDR_PORT_B = 3'h1;
	localparam logic [2:0] ADDR_CLOCK = 3'h2;
	localparam logic [2:0] ADDR_PHY = 3'h3;
	localparam logic [2:0] ADDR_REV = 3'h4;
	// port routing fields, vector index of msb-first bits
	localparam int F_GIGE = 7;
	localparam int F_FULL = 6;
	localparam int F_TENBIT = 4;
	localparam int F_FAST = 2;
	localparam int F_FLASH_RDY = 1;
	localparam int F_TOP = 0;
	// clock register fields
	localparam int C_SEL_LO = 7;
	localparam int C_SEL_HI = 6;
	localparam int C_SS_LO = 5;
	localparam int C_SS_HI = 4;
	localparam int C_PCI = 3;
	// phy mode register fields
	localparam int P0_DIS = 7;
	localparam int P0_XC = 6;
	localparam int PA_HI = 5;
	localparam int PA_LO = 4;
	localparam int P1_DIS = 3;
	localparam int P1_XC = 2;
	localparam int PB_HI = 1;
	localparam int PB_LO = 0;
	// revision nibbles
	localparam int R_HI = 7;
	localparam int R_LO = 4;
	localparam int S_HI = 3;
	localparam int S_LO = 0;
	// reset values and port B bit masks
	localparam logic [7:0] PORT_A_DEF = 8'hC2;
	localparam logic [7:0] PORT_B_DEF = 8'hC0;
	localparam logic [7:0] CLOCK_DEF = 8'hB0;
	localparam logic [7:0] PHY_DEF = 8'h44;
	localparam logic [7:0] PORT_B_RW = 8'hFD;
	localparam logic [7:0] PORT_B_RO = 8'h02;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// interface mode codes
	localparam logic [1:0] MODE_RGMII = 2'h0;
	localparam logic [1:0] MODE_RTBI = 2'h1;
	localparam logic [1:0] MODE_GMII = 2'h2;
	localparam logic [1:0] MODE_TBI = 2'h3;
	// decoded route vector
	localparam int RT_W = 7;
	localparam int RT_GIGE = 6;
	localparam int RT_EXP = 5;
	localparam int RT_GMII = 4;
	localparam int RT_RGMII = 3;
	localparam int RT_TBI = 2;
	localparam int RT_RTBI = 1;
	localparam int RT_MII = 0;
	// synchroniser lanes
	localparam int SY_W = 4;
	localparam int SY_BRST = 0;
	localparam int SY_HRST = 1;
	localparam int SY_TOG = 2;
	localparam int SY_FRDY = 3;
	localparam logic [3:0] SYNC_DEF = 4'h8;
	typedef logic [RT_W-1:0] bcr_route_t;
	// routing decode shared by both ports
	function automatic bcr_route_t bcr_route(input logic [7:0] r);
		bcr_route_t v;
		v = '0;
		v[RT_GIGE] = r[F_GIGE];
		v[RT_EXP] = ~r[F_GIGE];
		v[RT_GMII] = r[F_GIGE] & r[F_FULL];
		v[RT_RGMII] = r[F_GIGE] & ~r[F_FULL];
		v[RT_TBI] = r[F_GIGE] & r[F_TENBIT];
		v[RT_RTBI] = r[F_GIGE] & ~r[F_TENBIT];
		v[RT_MII] = ~r[F_GIGE] & r[F_FAST];
		return v;
	endfunction : bcr_route
endpackage : bcr_pkg

// *** verif/test_bcr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_bcr_regs
	import bcr_pkg::*;
;
	localparam logic [3:0] REV = 4'h1; // arbitrary value
	localparam logic [3:0] SUB = 4'h0; // arbitrary value
	// stimulus, named as the block's ports so that .* connects them
	logic CLOCK, RESET, BOARD_RESET, HARD_RESET, PHY_RESET_TOGGLE, FLASH_READY;
	logic [2:0] ADDR;
	logic [7:0] WDATA, RDATA;
	logic WR_STROBE, RD_STROBE;
	// observed pins
	logic PORT_A_GIGE_ENABLE, PORT_A_EXPANSION_ROUTE, PORT_A_TDM_ENABLE, PORT_A_GMII_ENABLE;
	logic PORT_A_RGMII_ENABLE, PORT_A_TBI_ENABLE, PORT_A_RTBI_ENABLE, PORT_A_MII_ENABLE;
	logic PORT_B_GIGE_ENABLE, PORT_B_EXPANSION_ROUTE, PORT_B_TDM_ENABLE, PORT_B_GMII_ENABLE;
	logic PORT_B_RGMII_ENABLE, PORT_B_TBI_ENABLE, PORT_B_RTBI_ENABLE, PORT_B_MII_ENABLE;
	logic RTC_RESET, FLASH_WRITE_PROTECT, PCI_CLK_ENABLE;
	logic LINK_CLK_SEL_LO, LINK_CLK_SEL_HI, LINK_SPREAD_SEL_LO, LINK_SPREAD_SEL_HI;
	logic PHY0_REFCLK_DISABLE, PHY0_EXCHANGE_ENABLE, PHY1_REFCLK_DISABLE, PHY1_EXCHANGE_ENABLE;
	logic [1:0] PORT_A_MODE_FIELD, PORT_B_MODE_FIELD;
	int errors = 0; // mismatch count
	int samples_checked = 0; // comparison count
	logic [7:0] sa, sb, sc, sp; // shadow copies of written bytes
	////////////////////////////////////////////////////////////////////////////////
	bcr_regs #(.REV_CODE(REV), .SUB_REV_CODE(SUB)) dut_u (.*);
	// free running clock, 8 ns period
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	// compare one value
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// wait whole cycles
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : tick
	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		WR_STROBE <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLOCK);
		WR_STROBE <= 1'b0;
	endtask : wr
	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
		@(posedge CLOCK);
		RD_STROBE <= 1'b1;
		ADDR <= a;
		@(posedge CLOCK);
		RD_STROBE <= 1'b0;
		#1;
		check(name, RDATA, exp);
	endtask : rd_chk
	// route pins expected from a byte, software bit n sits at r[7-n]
	function automatic logic [7:0] route_exp(input logic [7:0] r);
		return {r[7], ~r[7], ~r[7], r[7] & r[6], r[7] & ~r[6], r[7] & r[4], r[7] & ~r[4],
			~r[7] & r[2]};
	endfunction : route_exp
	// every output pin against the four control bytes
	task automatic check_pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
		input logic [7:0] p);
		check("port a route",
			{PORT_A_GIGE_ENABLE, PORT_A_EXPANSION_ROUTE, PORT_A_TDM_ENABLE,
			PORT_A_GMII_ENABLE, PORT_A_RGMII_ENABLE, PORT_A_TBI_ENABLE,
			PORT_A_RTBI_ENABLE, PORT_A_MII_ENABLE}, route_exp(a));
		check("port b route",
			{PORT_B_GIGE_ENABLE, PORT_B_EXPANSION_ROUTE, PORT_B_TDM_ENABLE,
			PORT_B_GMII_ENABLE, PORT_B_RGMII_ENABLE, PORT_B_TBI_ENABLE,
			PORT_B_RTBI_ENABLE, PORT_B_MII_ENABLE}, route_exp(b));
		check("clock chip reset", {7'h00, RTC_RESET}, {7'h00, a[0]});
		check("flash protect", {7'h00, FLASH_WRITE_PROTECT}, {7'h00, b[0]});
		check("clock pins",
			{3'h0, LINK_CLK_SEL_LO, LINK_CLK_SEL_HI, LINK_SPREAD_SEL_LO,
			LINK_SPREAD_SEL_HI, PCI_CLK_ENABLE}, {3'h0, c[7:3]});
		check("phy pins",
			{PHY0_REFCLK_DISABLE, PHY0_EXCHANGE_ENABLE, PORT_A_MODE_FIELD,
			PHY1_REFCLK_DISABLE, PHY1_EXCHANGE_ENABLE, PORT_B_MODE_FIELD}, p);
	endtask : check_pins
	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial begin
		tick(20000);
		errors++;
		$display("wrong value run length expected end seen timeout");
		complete_run();
	end
	// main sequence
	initial begin
		RESET = 1'b1;
		BOARD_RESET = 1'b0;
		HARD_RESET = 1'b0;
		PHY_RESET_TOGGLE = 1'b0;
		FLASH_READY = 1'b1;
		ADDR = 3'h0;
		WDATA = 8'h00;
		WR_STROBE = 1'b0;
		RD_STROBE = 1'b0;
		tick(8);
		RESET <= 1'b0;
		tick(1);
		#1;
		// defaults after power-on reset
		check_pins(8'hC2, 8'hC0, 8'hB0, 8'h44);
		rd_chk("port a", ADDR_PORT_A, 8'hC2);
		rd_chk("port b", ADDR_PORT_B, 8'hC2);
		rd_chk("clock", ADDR_CLOCK, 8'hB0);
		rd_chk("phy", ADDR_PHY, 8'h44);
		rd_chk("revision", ADDR_REV, {REV, SUB});
		@(posedge CLOCK);
		#1;
		check("read data idle", RDATA, 8'h00);
		// unmapped address takes nothing and reads zero
		wr(3'h5, 8'hFF);
		rd_chk("unmapped", 3'h5, 8'h00);
		sc = 8'hB0;
		sp = 8'h44;
		// every routing combination on both ports, reserved bits zero
		for (int i = 0; i < 16; i++) begin
			sa = {i[0], i[1], 1'b0, i[2], 1'b0, i[3], 1'b0, i[0] ^ i[3]};
			sb = {i[3], i[2], 1'b0, i[1], 1'b0, i[0], 1'b0, i[1]};
			wr(ADDR_PORT_A, sa);
			wr(ADDR_PORT_B, sb);
			tick(1);
			#1;
			check_pins(sa, sb, sc, sp);
			rd_chk("port a", ADDR_PORT_A, sa);
			rd_chk("port b", ADDR_PORT_B, sb | 8'h02);
		end
		// clock select, spread and pci bits
		for (int i = 0; i < 32; i++) begin
			sc = {i[0], i[1], i[2], i[3], i[4], 3'h0};
			wr(ADDR_CLOCK, sc);
			#1;
			check_pins(sa, sb, sc, sp);
			rd_chk("clock", ADDR_CLOCK, sc);
		end
		// phy byte with every mode code on both ports
		for (int i = 0; i < 16; i++) begin
			sp = {i[2], i[3], i[1], i[0], i[0], i[1], i[3], i[2]};
			wr(ADDR_PHY, sp);
			#1;
			check_pins(sa, sb, sc, sp);
			rd_chk("phy", ADDR_PHY, sp);
		end
		// flash busy reads back as zero, write to that bit ignored
		wr(ADDR_PORT_B, sb | 8'h02);
		FLASH_READY <= 1'b0;
		tick(3);
		rd_chk("flash busy", ADDR_PORT_B, sb);
		FLASH_READY <= 1'b1;
		tick(3);
		rd_chk("flash ready", ADDR_PORT_B, sb | 8'h02);
		// revision register is writable
		wr(ADDR_REV, 8'h5A);
		rd_chk("revision", ADDR_REV, 8'h5A);
		// board reset reloads port a only, a write during it is lost
		BOARD_RESET <= 1'b1;
		tick(4);
		wr(ADDR_PORT_A, 8'h00);
		BOARD_RESET <= 1'b0;
		tick(4);
		rd_chk("port a board reset", ADDR_PORT_A, 8'hC2);
		rd_chk("port b board reset", ADDR_PORT_B, sb | 8'h02);
		sa = 8'h01;
		wr(ADDR_PORT_A, sa);
		// hard reset reloads port b, clock and phy, not port a
		HARD_RESET <= 1'b1;
		tick(5);
		HARD_RESET <= 1'b0;
		tick(4);
		#1;
		check_pins(sa, 8'hC0, 8'hB0, 8'h44);
		rd_chk("port a hard reset", ADDR_PORT_A, sa);
		rd_chk("port b hard reset", ADDR_PORT_B, 8'hC2);
		rd_chk("clock hard reset", ADDR_CLOCK, 8'hB0);
		rd_chk("revision hard reset", ADDR_REV, 8'h5A);
		// toggle reloads phy only after it falls back
		// port A mode left at ten-bit so the reload is visible
		wr(ADDR_PHY, 8'h30);
		PHY_RESET_TOGGLE <= 1'b1;
		tick(4);
		rd_chk("phy toggle high", ADDR_PHY, 8'h30);
		PHY_RESET_TOGGLE <= 1'b0;
		tick(4);
		rd_chk("phy toggle low", ADDR_PHY, 8'h44);
		// second power-on reset in mid-run
		wr(ADDR_CLOCK, 8'h08);
		RESET <= 1'b1;
		tick(2);
		RESET <= 1'b0;
		tick(1);
		#1;
		check_pins(8'hC2, 8'hC0, 8'hB0, 8'h44);
		rd_chk("revision reset", ADDR_REV, {REV, SUB});
		complete_run();
	end
endmodule : test_bcr_regs
`default_nettype wire
